// >>> src/dfcs_pkg.sv
package dfcs_pkg;

    // ========================================
    // Command word bit positions
    localparam int CMD_OFF1 = 0;
    localparam int CMD_OFF2 = 1;
    localparam int CMD_OFF3 = 2;
    localparam int CMD_COAST = 3;
    localparam int CMD_QSTOP = 4;
    localparam int CMD_HOLD = 5;
    localparam int CMD_START = 6;
    localparam int CMD_RESET = 7;
    localparam int CMD_JOG1 = 8;
    localparam int CMD_JOG2 = 9;
    localparam int CMD_VALID = 10;
    localparam int CMD_SLOW = 11;
    localparam int CMD_CATCH = 12;
    localparam int CMD_SET_LSB = 13;
    localparam int CMD_SET_MSB = 14;
    localparam int CMD_REV = 15;

    // ========================================
    // State word bit positions
    localparam int ST_CTRL_RDY = 0;
    localparam int ST_DRV_RDY = 1;
    localparam int ST_ENABLE = 2;
    localparam int ST_TRIP = 3;
    localparam int ST_ON2 = 4;
    localparam int ST_ON3 = 5;
    localparam int ST_NO_START = 6;
    localparam int ST_WARN = 7;
    localparam int ST_AT_REF = 8;
    localparam int ST_BUS_CTRL = 9;
    localparam int ST_FREQ_OK = 10;
    localparam int ST_RUNNING = 11;
    localparam int ST_AUTOSTOP = 12;
    localparam int ST_VOLT = 13;
    localparam int ST_TORQUE = 14;
    localparam int ST_TIMER = 15;

    // ========================================
    // Reset values
    localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
    localparam logic [15:0] STATE_RESET_VAL = 16'h0000;

    // ========================================
    // Source selections for coast, quick stop, start and reverse; with DIN selected for reverse, the reverse command stays off
    typedef enum logic [1:0] {
        DFCS_SRC_DIN = 2'b00,
        DFCS_SRC_BUS = 2'b01,
        DFCS_SRC_AND = 2'b10,
        DFCS_SRC_OR = 2'b11
    } dfcs_src_t;

    typedef enum logic [1:0] {
        DFCS_SPD_REF = 2'b00,
        DFCS_SPD_JOG1 = 2'b01,
        DFCS_SPD_JOG2 = 2'b10
    } dfcs_spd_t;

    typedef enum logic [1:0] {
        DFCS_ADJ_NONE = 2'b00,
        DFCS_ADJ_DOWN = 2'b01,
        DFCS_ADJ_UP = 2'b10
    } dfcs_adj_t;

    // Stop request, least severe first
    typedef enum logic [2:0] {
        DFCS_STOP_NONE = 3'b000,
        DFCS_STOP_RAMP = 3'b001,
        DFCS_STOP_QUICK = 3'b010,
        DFCS_STOP_COAST = 3'b011
    } dfcs_stop_t;

    // Drive feedback used by the state word
    typedef struct packed {
        logic trip_event;
        logic warning;
        logic at_reference;
        logic bus_control;
        logic freq_limit_ok;
        logic freq_nonzero;
        logic overtemp_stop;
        logic volt_limit;
        logic torque_limit;
        logic timer_limit;
    } dfcs_fb_t;

    // Configuration settings
    typedef struct packed {
        dfcs_src_t coast_src;
        dfcs_src_t qstop_src;
        dfcs_src_t start_src;
        dfcs_src_t rev_src;
        logic multi_setup;
        logic relay_on_stop;
    } dfcs_cfg_t;

    // Decoded commands toward the motor control
    typedef struct packed {
        dfcs_stop_t stop_mode;
        logic start_ok;
        logic freeze;
        dfcs_spd_t speed_sel;
        dfcs_adj_t ref_adj;
        logic [1:0] setup_sel;
        logic reverse;
        logic fault_reset;
        logic stop_relay;
    } dfcs_cmd_t;

endpackage

// >>> src/dfcs_src_gate.sv
`timescale 1ns/1ns
module dfcs_src_gate
    import dfcs_pkg::*;
(
    // Selection and inputs
    input wire dfcs_src_t sel,
    input wire logic bus_bit,
    input wire logic din_bit,
    // Combined level
    output logic out_bit
);

    assign out_bit = (sel == DFCS_SRC_DIN) ? din_bit :
                     (sel == DFCS_SRC_BUS) ? bus_bit :
                     (sel == DFCS_SRC_AND) ? (bus_bit & din_bit) :
                     (bus_bit | din_bit);

endmodule

// >>> src/dfcs_edge_det.sv
`timescale 1ns/1ns
module dfcs_edge_det (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sampled level and its sampling strobe
    input wire logic sample,
    input wire logic level,
    // One-cycle pulse on a 0-to-1 step
    output logic rise
);

    logic prev_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else if (sample) begin
            prev_q <= level;
        end
    end

    assign rise = sample & level & ~prev_q;

endmodule

// >>> src/dfcs_ctrl_word.sv
`timescale 1ns/1ns
module dfcs_ctrl_word
    import dfcs_pkg::*;
#(
    parameter int WORD_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Telegram exchange
    input wire logic telegram_valid,
    input wire logic [WORD_W-1:0] drive_command_word,
    output logic [WORD_W-1:0] drive_state_word,
    output logic state_valid,
    // Digital inputs and settings
    input wire logic din_coast_n,
    input wire logic din_qstop_n,
    input wire logic din_start,
    input wire logic din_reverse,
    input wire dfcs_cfg_t cfg,
    // Drive feedback
    input wire dfcs_fb_t fb,
    // Decoded commands
    output dfcs_cmd_t cmd
);

    // ========================================
    // Telegram capture
    logic [WORD_W-1:0] cw_q;
    logic [WORD_W-1:0] cw_d;
    logic accept;

    // Whole word dropped when data-valid is low
    assign accept = telegram_valid & drive_command_word[CMD_VALID];
    assign cw_d = accept ? drive_command_word : cw_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cw_q <= CMD_RESET_VAL;
        end else begin
            cw_q <= cw_d;
        end
    end

    // ========================================
    // Fault reset edge, seen only on accepted telegrams
    logic reset_rise;

    dfcs_edge_det u_reset_edge (
        .clk(clk),
        .rst(rst),
        .sample(accept),
        .level(drive_command_word[CMD_RESET]),
        .rise(reset_rise)
    );

    // ========================================
    // Source gating with digital inputs
    logic coast_ok;
    logic qstop_ok;
    logic start_ok_g;
    logic rev_g;

    dfcs_src_gate u_coast_gate (
        .sel(cfg.coast_src),
        .bus_bit(cw_q[CMD_COAST]),
        .din_bit(din_coast_n),
        .out_bit(coast_ok)
    );

    dfcs_src_gate u_qstop_gate (
        .sel(cfg.qstop_src),
        .bus_bit(cw_q[CMD_QSTOP]),
        .din_bit(din_qstop_n),
        .out_bit(qstop_ok)
    );

    dfcs_src_gate u_start_gate (
        .sel(cfg.start_src),
        .bus_bit(cw_q[CMD_START]),
        .din_bit(din_start),
        .out_bit(start_ok_g)
    );

    dfcs_src_gate u_rev_gate (
        .sel(cfg.rev_src),
        .bus_bit(cw_q[CMD_REV]),
        .din_bit(din_reverse),
        .out_bit(rev_g)
    );

    // ========================================
    // Trip latch
    logic trip_q;
    logic trip_d;

    // New trip wins over a reset arriving in the same cycle
    assign trip_d = fb.trip_event | (trip_q & ~reset_rise);

    // ========================================
    // Stop selection; coast beats quick stop beats ramp
    logic off_all_on;
    logic jog_allowed;
    dfcs_stop_t stop_w;

    assign off_all_on = cw_q[CMD_OFF1] & cw_q[CMD_OFF2] & cw_q[CMD_OFF3];
    assign stop_w = (~cw_q[CMD_OFF2] | ~coast_ok) ? DFCS_STOP_COAST :
                    (~cw_q[CMD_OFF3]) ? DFCS_STOP_QUICK :
                    (~cw_q[CMD_OFF1] | ~start_ok_g) ? DFCS_STOP_RAMP :
                    DFCS_STOP_NONE;
    // Jog is a qualified exception to the quick stop on bit 04
    assign jog_allowed = off_all_on & ~cw_q[CMD_QSTOP] & cw_q[CMD_COAST];

    logic quick_w;
    dfcs_stop_t stop_final;
    assign quick_w = ~qstop_ok & ~jog_allowed & (stop_w == DFCS_STOP_NONE | 
                     stop_w == DFCS_STOP_RAMP);
    assign stop_final = quick_w ? DFCS_STOP_QUICK : stop_w;

    // ========================================
    // Speed source and reference adjust
    dfcs_spd_t spd_w;
    dfcs_adj_t adj_w;

    assign spd_w = (jog_allowed & cw_q[CMD_JOG1]) ? DFCS_SPD_JOG1 :
                   (jog_allowed & cw_q[CMD_JOG2]) ? DFCS_SPD_JOG2 :
                   DFCS_SPD_REF;
    // Slow-down has priority when both are set
    assign adj_w = cw_q[CMD_SLOW] ? DFCS_ADJ_DOWN :
                   cw_q[CMD_CATCH] ? DFCS_ADJ_UP :
                   DFCS_ADJ_NONE;

    // ========================================
    // Set-up selection, held when multi-set-up is off
    logic [1:0] setup_q;
    logic [1:0] setup_d;

    assign setup_d = cfg.multi_setup ? {cw_q[CMD_SET_MSB], cw_q[CMD_SET_LSB]} : setup_q;

    // ========================================
    // Start-inhibit flag
    logic inhibit_q;
    logic inhibit_d;
    logic inhibit_clear;
    logic inhibit_set;

    assign inhibit_clear = accept & ~drive_command_word[CMD_OFF1] &
                           drive_command_word[CMD_OFF2] & drive_command_word[CMD_OFF3];
    // Off2/off3 taken from the accepted word, so an old stored off cannot mask the clear
    assign inhibit_set = reset_rise | (accept & (~drive_command_word[CMD_OFF2] |
                         ~drive_command_word[CMD_OFF3]));
    // Set wins over clear
    assign inhibit_d = inhibit_set ? 1'b1 : (inhibit_clear ? 1'b0 : inhibit_q);

    // ========================================
    // Command outputs
    dfcs_cmd_t cmd_d;
    logic start_sig;
    logic relay_w;

    assign start_sig = (stop_final == DFCS_STOP_NONE) & ~trip_q & ~inhibit_q;
    // Relay drives once the motor has stopped after an off command
    assign relay_w = cfg.relay_on_stop & ~fb.freq_nonzero &
                     (stop_final != DFCS_STOP_NONE);

    always_comb begin
        cmd_d = '0;
        cmd_d.stop_mode = stop_final;
        cmd_d.start_ok = start_sig;
        cmd_d.freeze = ~cw_q[CMD_HOLD];
        cmd_d.speed_sel = spd_w;
        cmd_d.ref_adj = adj_w;
        cmd_d.setup_sel = setup_d;
        cmd_d.reverse = (cfg.rev_src != DFCS_SRC_DIN) & rev_g;
        cmd_d.fault_reset = reset_rise;
        cmd_d.stop_relay = relay_w;
    end

    // ========================================
    // State word assembly
    logic [WORD_W-1:0] sw_d;
    logic ready_w;

    assign ready_w = off_all_on & ~trip_q;

    always_comb begin
        sw_d = STATE_RESET_VAL;
        sw_d[ST_CTRL_RDY] = ready_w;
        sw_d[ST_DRV_RDY] = ready_w & ~inhibit_q;
        sw_d[ST_ENABLE] = ready_w;
        sw_d[ST_TRIP] = trip_q;
        sw_d[ST_ON2] = cw_q[CMD_OFF2];
        sw_d[ST_ON3] = cw_q[CMD_OFF3];
        sw_d[ST_NO_START] = inhibit_q;
        sw_d[ST_WARN] = fb.warning;
        sw_d[ST_AT_REF] = fb.at_reference;
        sw_d[ST_BUS_CTRL] = fb.bus_control;
        sw_d[ST_FREQ_OK] = fb.freq_limit_ok;
        sw_d[ST_RUNNING] = start_sig | fb.freq_nonzero;
        sw_d[ST_AUTOSTOP] = fb.overtemp_stop;
        sw_d[ST_VOLT] = fb.volt_limit;
        sw_d[ST_TORQUE] = fb.torque_limit;
        sw_d[ST_TIMER] = fb.timer_limit;
    end

    // ========================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            trip_q <= 1'b0;
            setup_q <= 2'h0;
            inhibit_q <= 1'b1;
        end else begin
            trip_q <= trip_d;
            setup_q <= setup_d;
            inhibit_q <= inhibit_d;
        end
    end

    // State word is refreshed every cycle, flagged once per telegram
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_state_word <= STATE_RESET_VAL;
            state_valid <= 1'b0;
            cmd <= '0;
        end else begin
            drive_state_word <= sw_d;
            state_valid <= telegram_valid;
            cmd <= cmd_d;
        end
    end

endmodule

// >>> testbench/dfcs_ctrl_word_properties.sv
`timescale 1ns/1ns
module dfcs_ctrl_word_properties
    import dfcs_pkg::*;
#(
    parameter int WORD_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Telegram exchange
    input wire logic telegram_valid,
    input wire logic [WORD_W-1:0] drive_command_word,
    input wire logic [WORD_W-1:0] drive_state_word,
    input wire logic state_valid,
    // Feedback and decoded commands
    input wire dfcs_fb_t fb,
    input wire dfcs_cmd_t cmd
);
    // ============
    // Helper logic
    logic acc;
    logic [2:0] rst_win_q;
    logic [2:0] rst_win_d;
    assign acc = telegram_valid && drive_command_word[CMD_VALID];
    // Trip may only fall a few cycles after an accepted reset word
    assign rst_win_d = (acc && drive_command_word[CMD_RESET]) ? 3'h6 :
                       (rst_win_q != 3'h0) ? rst_win_q - 3'h1 : 3'h0;
    always_ff @(posedge clk) begin
        rst_win_q <= rst ? 3'h0 : rst_win_d;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ignored;
        telegram_valid && !drive_command_word[CMD_VALID];
    endsequence
    sequence s_clear_inhibit;
        acc && drive_command_word[2:0] == 3'b110 && !drive_command_word[CMD_RESET];
    endsequence

    // ============
    // Properties
    AST_STATE_VALID: assert property (!$past(rst) |-> state_valid == $past(telegram_valid))
        else $error("state_valid not one cycle after telegram_valid");
    AST_IGNORED: assert property (s_ignored |-> ##3 $stable(drive_state_word[5:4]))
        else $error("ignored telegram changed the state word");
    AST_MIRROR: assert property (acc |-> ##3 drive_state_word[5:4] == $past(drive_command_word[2:1], 3))
        else $error("state bits 5:4 do not mirror command bits 2:1");
    AST_FAULT_RESET: assert property (cmd.fault_reset |->
        ($past(acc, 1) && $past(drive_command_word[CMD_RESET], 1)) ##1 !cmd.fault_reset)
        else $error("fault reset without reset word or too long");
    AST_TRIP_HOLD: assert property (!$past(rst) && $fell(drive_state_word[ST_TRIP]) |-> rst_win_q != 3'h0)
        else $error("trip cleared without a reset word");
    AST_READY: assert property (drive_state_word[ST_CTRL_RDY] |->
        drive_state_word[ST_ON2] && drive_state_word[ST_ON3] && !drive_state_word[ST_TRIP])
        else $error("control ready with off or trip");
    AST_ENABLE: assert property (drive_state_word[ST_ENABLE] == drive_state_word[ST_CTRL_RDY])
        else $error("enable differs from control ready");
    AST_LIMITS: assert property (!$past(rst) |-> drive_state_word[15:13] ==
        {$past(fb.timer_limit), $past(fb.torque_limit), $past(fb.volt_limit)})
        else $error("limit flags do not follow feedback");
    AST_RUNNING: assert property (!$past(rst) && $past(fb.freq_nonzero) |-> drive_state_word[ST_RUNNING])
        else $error("running flag low with nonzero frequency");
    AST_POWERUP: assert property ($past(rst, 2) && !$past(rst) |-> drive_state_word[ST_NO_START])
        else $error("start inhibit not set after power-up");
    AST_INHIBIT_CLR: assert property (s_clear_inhibit |-> ##3 !drive_state_word[ST_NO_START])
        else $error("start inhibit not cleared");
endmodule

bind dfcs_ctrl_word dfcs_ctrl_word_properties #(.WORD_W(WORD_W)) props_i (
    .clk(clk),
    .rst(rst),
    .telegram_valid(telegram_valid),
    .drive_command_word(drive_command_word),
    .drive_state_word(drive_state_word),
    .state_valid(state_valid),
    .fb(fb),
    .cmd(cmd)
);

// >>> testbench/dfcs_master_model.sv
`timescale 1ns/1ns
module dfcs_master_model (
    // Clock
    input wire logic clk,
    // Telegram toward the drive
    output logic telegram_valid,
    output logic [15:0] drive_command_word
);
    initial begin
        telegram_valid = 1'b0;
        drive_command_word = 16'hffff;
    end
    // Word is not held after a telegram; inverse avoids a stale match
    task automatic send(input logic [15:0] w);
        @(posedge clk);
        #1;
        telegram_valid = 1'b1;
        drive_command_word = w;
        @(posedge clk);
        #1;
        telegram_valid = 1'b0;
        drive_command_word = ~w;
    endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ns
module tb
    import dfcs_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic telegram_valid;
    logic [15:0] drive_command_word;
    logic [15:0] drive_state_word;
    logic state_valid;
    logic din_coast_n = 1'b1;
    logic din_qstop_n = 1'b1;
    logic din_start = 1'b0;
    logic din_reverse = 1'b0;
    dfcs_cfg_t cfg = '{DFCS_SRC_BUS, DFCS_SRC_BUS, DFCS_SRC_BUS, DFCS_SRC_BUS, 1'b1, 1'b1};
    dfcs_fb_t fb = '0;
    dfcs_cmd_t cmd;
    int fails = 0;
    int comparisons = 0;
    logic [15:0] g;
    logic [15:0] e;
    logic [15:0] w;
    logic fr;
    logic [15:0] words [16] = '{16'h047f, 16'h047e, 16'h047d, 16'h047b, 16'h0477, 16'h043f,
        16'h045f, 16'h056f, 16'h066f, 16'h057f, 16'h0c7f, 16'h147f, 16'h1c7f, 16'h247f,
        16'h647f, 16'h847f};
    // Expected {speed, adjust, stop, freeze}
    logic [7:0] exps [16] = '{8'h00, 8'h02, 8'h06, 8'h04, 8'h06, 8'h02, 8'h01, 8'h40,
        8'h80, 8'h00, 8'h10, 8'h20, 8'h10, 8'h00, 8'h00, 8'h00};

    always #4 clk = ~clk;

    dfcs_master_model dfcs_master_model_i (
        .clk(clk),
        .telegram_valid(telegram_valid),
        .drive_command_word(drive_command_word)
    );
    dfcs_ctrl_word dfcs_ctrl_word_i (
        .clk(clk),
        .rst(rst),
        .telegram_valid(telegram_valid),
        .drive_command_word(drive_command_word),
        .drive_state_word(drive_state_word),
        .state_valid(state_valid),
        .din_coast_n(din_coast_n),
        .din_qstop_n(din_qstop_n),
        .din_start(din_start),
        .din_reverse(din_reverse),
        .cfg(cfg),
        .fb(fb),
        .cmd(cmd)
    );

    // ============
    // Tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Telegram, then the two-edge answer
    task automatic tel(input logic [15:0] wd);
        dfcs_master_model_i.send(wd);
        // Both pulses stand only in the cycle after capture
        check("state_valid", {15'h0, state_valid}, 16'h0001);
        fr = cmd.fault_reset;
        cycles(1);
        g = {5'h0, cmd.setup_sel, cmd.reverse, cmd.speed_sel, cmd.ref_adj, cmd.stop_mode,
            cmd.freeze};
    endtask
    task automatic bit_is(input string name, input int pos, input logic v);
        check(name, {15'h0, drive_state_word[pos]}, {15'h0, v});
    endtask

    // ============
    // Scenarios
    initial begin
        cycles(20);
        rst = 1'b0;
        cycles(2);
        bit_is("inhibit_powerup", ST_NO_START, 1'b1);
        tel(16'h0406);
        bit_is("inhibit_clear", ST_NO_START, 1'b0);
        for (int i = 0; i < 16; i++) begin
            w = words[i];
            tel(w);
            e = {5'h0, w[14:13], w[15], exps[i]};
            check("stop", {12'h0, g[3:0]}, {12'h0, e[3:0]});
            check("select", {9'h0, g[10:4]}, {9'h0, e[10:4]});
            check("mirror", {12'h0, drive_state_word[5:4], drive_state_word[2],
                drive_state_word[0]}, {12'h0, w[2:1], &w[2:0], &w[2:0]});
        end
        tel(16'h007d);
        check("ignored", g, 16'h0100);
        bit_is("ignored_st", ST_ON2, 1'b1);
        fb.trip_event = 1'b1;
        cycles(1);
        fb.trip_event = 1'b0;
        cycles(2);
        bit_is("trip", ST_TRIP, 1'b1);
        bit_is("ready_trip", ST_CTRL_RDY, 1'b0);
        tel(16'h0080);
        bit_is("trip_ignored", ST_TRIP, 1'b1);
        tel(16'h047f);
        check("start_blocked", {15'h0, cmd.start_ok}, 16'h0000);
        tel(16'h04ff);
        check("fault_reset", {15'h0, fr}, 16'h0001);
        cycles(2);
        bit_is("trip_cleared", ST_TRIP, 1'b0);
        bit_is("inhibit_reset", ST_NO_START, 1'b1);
        tel(16'h04ff);
        check("no_reset", {15'h0, fr}, 16'h0000);
        fb = '{volt_limit: 1'b1, timer_limit: 1'b1, freq_nonzero: 1'b1, default: 1'b0};
        cycles(1);
        check("limits", {13'h0, drive_state_word[15:13]}, 16'h0005);
        bit_is("running", ST_RUNNING, 1'b1);
        fb = '{torque_limit: 1'b1, default: 1'b0};
        cycles(1);
        check("limits", {13'h0, drive_state_word[15:13]}, 16'h0002);
        bit_is("running", ST_RUNNING, 1'b0);
        wrap_up();
    end

    // Hang guard
    initial begin
        cycles(20000);
        fails++;
        wrap_up();
    end
endmodule
